// file: rtl/ecc_pkg.sv
// Types of the receive clock correction elastic buffer.
// Assumes the constants header sits beside it.
`include "ecc_regs.svh"
package ecc_pkg;
   typedef logic [8:0] ecc_char_t;
endpackage

// file: rtl/ecc_regs.svh
// Constants of the receive clock correction elastic buffer.
// Assumes inclusion by the package and the design files only.
`ifndef ECC_REGS_SVH
`define ECC_REGS_SVH
`define ECC_DEPTH      32
`define ECC_PTR_W      5
`define ECC_LVL_W      6
`define ECC_MAX_SYM    4
`define ECC_MAX_LAT    6'h14
`define ECC_MIN_LAT    6'h12
`define ECC_CC_SYMBOL  8'h1c
`define ECC_SEQ_LEN    3'h1
`define ECC_SKID_DEPTH 2
`endif

// file: rtl/ecc_skid.sv
// Two-entry valid/ready buffer in front of the user-side consumer.
// Assumes one clock domain, sys_clk.
module ecc_skid
   import ecc_pkg::*;
(
   input  wire logic      sys_clk,
   input  wire logic      rstn,
   input  wire ecc_char_t in_data,
   input  wire logic      in_valid,
   output logic           in_ready,
   output ecc_char_t      out_data,
   output logic           out_valid,
   input  wire logic      out_ready
);
   typedef struct packed {
      ecc_char_t [1:0] mem;
      logic            wp;
      logic            rp;
      logic [1:0]      cnt;
      logic            in_ready;
      logic            out_valid;
      ecc_char_t       out_data;
   } ecc_skid_st_t;
   ecc_skid_st_t s_ff, nxt_s;
   always_comb begin
      logic push;
      logic pop;
      nxt_s = s_ff;
      push = in_valid && s_ff.in_ready;
      pop  = s_ff.out_valid && out_ready;
      if (push) begin
         nxt_s.mem[s_ff.wp] = in_data;
         nxt_s.wp = ~s_ff.wp;
      end
      if (pop) begin
         nxt_s.rp = ~s_ff.rp;
      end
      nxt_s.cnt = s_ff.cnt + {1'b0, push} - {1'b0, pop};
      nxt_s.in_ready = (nxt_s.cnt != 2'(`ECC_SKID_DEPTH));
      nxt_s.out_valid = (nxt_s.cnt != 2'h0);
      nxt_s.out_data = nxt_s.mem[nxt_s.rp];
      if (!rstn) begin
         nxt_s = '0;
      end
   end
   always_ff @(posedge sys_clk) begin
      s_ff <= nxt_s;
   end
   assign in_ready  = s_ff.in_ready;
   assign out_valid = s_ff.out_valid;
   assign out_data  = s_ff.out_data;
endmodule

// file: rtl/ecc_top.sv
// Receive elastic buffer with clock correction by sequence insert/delete.
// Assumes the line clock and line data come from outside; sampled here.
module ecc_top
   import ecc_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        line_clk,
   input  wire logic [7:0]  line_data,
   input  wire logic        line_is_k,
   input  wire logic        line_inv_disp,
   input  wire logic        cc_enable,
   input  wire logic        cc_two_seq,
   input  wire logic [2:0]  cc_seq_len,
   input  wire logic [5:0]  cc_max_lat,
   input  wire logic [5:0]  cc_min_lat,
   input  wire logic [63:0] cc_sym,
   input  wire logic [7:0]  cc_sym_k,
   input  wire logic [7:0]  cc_sym_dc,
   input  wire logic [7:0]  cc_sym_inv,
   output logic [7:0]       rx_data,
   output logic             rx_is_k,
   output logic             rx_valid,
   input  wire logic        rx_ready,
   output logic [5:0]       buf_level,
   output logic             cc_deleted,
   output logic             cc_inserted,
   output logic             buf_overflow
);
   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [2:0]                 lc_sync;
      logic [1:0][7:0]            d_s1;
      logic [1:0]                 k_s1;
      logic [1:0]                 i_s1;
      logic [3:0][9:0]            hist;
      logic [2:0]                 hist_cnt;
      logic [`ECC_DEPTH-1:0][8:0] mem;
      logic [`ECC_PTR_W-1:0]      wp;
      logic [`ECC_PTR_W-1:0]      rp;
      logic [`ECC_LVL_W-1:0]      lvl;
      logic [3:0][8:0]            last_seq;
      logic [2:0]                 last_len;
      logic                       have_seq;
      logic [2:0]                 ins_idx;
      logic                       ins_act;
      logic [2:0]                 sym_idx;
      logic                       del_act;
      logic                       cc_deleted;
      logic                       cc_inserted;
      logic                       ovf;
   } ecc_st_t;
   ecc_st_t s_ff, nxt_s;
   ecc_char_t sk_in;
   logic      sk_valid;
   logic      sk_ready;
   ecc_char_t sk_out;
   logic      sk_out_valid;
   // ************************************************************
   // Sequence matcher
   // ************************************************************
   logic [1:0][3:0] pos_ok;
   logic [1:0]      seq_hit;
   for (genvar q = 0; q < 2; q++) begin : g_seq
      for (genvar p = 0; p < `ECC_MAX_SYM; p++) begin : g_pos
         localparam int B = q * `ECC_MAX_SYM + p;
         logic [9:0] h;
         assign h = s_ff.hist[p];
         // Unused slots beyond length act as wildcards
         assign pos_ok[q][p] = (3'(p) >= cc_seq_len) || cc_sym_dc[B]
            || ((h[7:0] == cc_sym[B*8 +: 8])
                && (h[8] == cc_sym_k[B])
                && (!h[9] || cc_sym_inv[B]));
      end
      assign seq_hit[q] = (&pos_ok[q]) && (s_ff.hist_cnt >= cc_seq_len);
   end
   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic                  edge_rise;
      logic                  hit;
      logic                  push;
      logic                  pop;
      logic [`ECC_PTR_W-1:0] wpn;
      nxt_s = s_ff;
      nxt_s.cc_deleted  = 1'b0;
      nxt_s.cc_inserted = 1'b0;
      // Data sampled twice with sys_clk, then captured on the synced line clock rising edge
      nxt_s.lc_sync = {s_ff.lc_sync[1:0], line_clk};
      nxt_s.d_s1 = {s_ff.d_s1[0], line_data};
      nxt_s.k_s1 = {s_ff.k_s1[0], line_is_k};
      nxt_s.i_s1 = {s_ff.i_s1[0], line_inv_disp};
      edge_rise = s_ff.lc_sync[1] && !s_ff.lc_sync[2];
      hit  = cc_enable && (seq_hit[0] || (cc_two_seq && seq_hit[1]));
      wpn  = s_ff.wp;
      push = 1'b0;
      if (edge_rise) begin
         nxt_s.hist = {s_ff.hist[2:0], {s_ff.i_s1[1], s_ff.k_s1[1], s_ff.d_s1[1]}};
         // Sliding window: count saturates so every character leaves it once
         nxt_s.hist_cnt = (s_ff.hist_cnt >= cc_seq_len) ? cc_seq_len : s_ff.hist_cnt + 3'h1;
      end
      // Whole sequences are written once complete, so delete drops them all
      if (hit && !s_ff.del_act && !edge_rise) begin
         nxt_s.del_act = 1'b1;
         nxt_s.hist_cnt = 3'h0;
         for (int i = 0; i < `ECC_MAX_SYM; i++) begin
            nxt_s.last_seq[i] = s_ff.hist[i][8:0];
         end
         nxt_s.last_len = cc_seq_len;
         nxt_s.have_seq = 1'b1;
         if (s_ff.lvl > cc_max_lat) begin
            nxt_s.cc_deleted = 1'b1;
            nxt_s.sym_idx = 3'h0;
         end else begin
            nxt_s.sym_idx = cc_seq_len;
         end
      end else if (s_ff.del_act && !edge_rise) begin
         if (s_ff.sym_idx != 3'h0 && s_ff.lvl < 6'(`ECC_DEPTH)) begin
            push = 1'b1;
            nxt_s.mem[s_ff.wp] = s_ff.last_seq[s_ff.sym_idx - 3'h1];
            nxt_s.sym_idx = s_ff.sym_idx - 3'h1;
         end else if (s_ff.sym_idx == 3'h0) begin
            nxt_s.del_act = 1'b0;
         end
      end else if (edge_rise && !s_ff.del_act && s_ff.hist_cnt == 3'h0) begin
         // Plain data after a match or reset is forwarded later by the window
      end
      // Characters older than the window that never formed a sequence
      if (edge_rise && !hit && s_ff.hist_cnt >= cc_seq_len && !s_ff.del_act) begin
         if (s_ff.lvl < 6'(`ECC_DEPTH)) begin
            push = 1'b1;
            nxt_s.mem[s_ff.wp] = s_ff.hist[cc_seq_len - 3'h1][8:0];
         end else begin
            nxt_s.ovf = 1'b1;
         end
      end
      if (push) begin
         wpn = s_ff.wp + 5'h1;
      end
      nxt_s.wp = wpn;
      // Read side; underflow guard inserts a whole stored sequence
      pop = 1'b0;
      if (s_ff.ins_act) begin
         if (sk_ready) begin
            nxt_s.ins_idx = s_ff.ins_idx + 3'h1;
            if (s_ff.ins_idx + 3'h1 == s_ff.last_len) begin
               nxt_s.ins_act = 1'b0;
            end
         end
      end else if (sk_ready && s_ff.lvl != 6'h0) begin
         // Hold back below minimum latency; a sequence fills the gap
         if (s_ff.lvl >= cc_min_lat || !cc_enable) begin
            pop = 1'b1;
         end else if (s_ff.have_seq && s_ff.lvl < cc_min_lat) begin
            nxt_s.ins_act = 1'b1;
            nxt_s.ins_idx = 3'h0;
            nxt_s.cc_inserted = 1'b1;
         end
      end
      if (pop) begin
         nxt_s.rp = s_ff.rp + 5'h1;
      end
      nxt_s.lvl = s_ff.lvl + 6'(push) - 6'(pop);
      if (!rstn) begin
         nxt_s = '0;
      end
   end
   always_ff @(posedge sys_clk) begin
      s_ff <= nxt_s;
   end
   assign sk_in    = s_ff.ins_act ? s_ff.last_seq[s_ff.last_len - 3'h1 - s_ff.ins_idx]
                                  : s_ff.mem[s_ff.rp];
   assign sk_valid = s_ff.ins_act || (sk_ready && s_ff.lvl != 6'h0
                                      && (s_ff.lvl >= cc_min_lat || !cc_enable));
   ecc_skid u_skid (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .in_data   (sk_in),
      .in_valid  (sk_valid),
      .in_ready  (sk_ready),
      .out_data  (sk_out),
      .out_valid (sk_out_valid),
      .out_ready (rx_ready)
   );
   assign rx_data      = sk_out[7:0];
   assign rx_is_k      = sk_out[8];
   assign rx_valid     = sk_out_valid;
   assign buf_level    = s_ff.lvl;
   assign cc_deleted   = s_ff.cc_deleted;
   assign cc_inserted  = s_ff.cc_inserted;
   assign buf_overflow = s_ff.ovf;
   // ************************************************************
   // Checks
   // ************************************************************
   property p_level_bound;
      @(posedge sys_clk) disable iff (!rstn) s_ff.lvl <= 6'(`ECC_DEPTH);
   endproperty
   a_level_bound: assert property (p_level_bound) else $error("level above depth");
   property p_del_when_high;
      @(posedge sys_clk) disable iff (!rstn) cc_deleted |-> $past(s_ff.lvl) > $past(cc_max_lat);
   endproperty
   a_del_when_high: assert property (p_del_when_high) else $error("delete while not above max");
   property p_ins_when_low;
      @(posedge sys_clk) disable iff (!rstn) cc_inserted |-> $past(s_ff.lvl) < $past(cc_min_lat);
   endproperty
   a_ins_when_low: assert property (p_ins_when_low) else $error("insert while not below min");
   property p_no_corr_disabled;
      @(posedge sys_clk) disable iff (!rstn) !$past(cc_enable) |-> !cc_deleted;
   endproperty
   a_no_corr_disabled: assert property (p_no_corr_disabled) else $error("correction while disabled");
   property p_no_pop_low;
      @(posedge sys_clk) disable iff (!rstn) cc_enable && s_ff.lvl < cc_min_lat |=> $stable(s_ff.rp);
   endproperty
   a_no_pop_low: assert property (p_no_pop_low) else $error("buffer read below minimum");
   property p_rx_hold;
      @(posedge sys_clk) disable iff (!rstn) rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("output changed while stalled");
endmodule

// file: tb/ecc_tx_model.sv
// Far-end transmitter model: one character per line clock period.
// Assumes sys_clk at 100 ns; line clock stands still between characters.
module ecc_tx_model
(
   input  wire logic       sys_clk,
   output logic            line_clk,
   output logic [7:0]      line_data,
   output logic            line_is_k,
   output logic            line_inv_disp
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      line_clk      = 1'b0;
      line_data     = 8'h00;
      line_is_k     = 1'b0;
      line_inv_disp = 1'b0;
   end
   // *****************
   // Character sender
   // *****************
   // At least 900 ns period; data released to its inverse so stale data never matches
   task automatic send(input logic [9:0] c);
      @(posedge sys_clk);
      line_data     <= c[7:0];
      line_is_k     <= c[8];
      line_inv_disp <= c[9];
      repeat (4) @(posedge sys_clk);
      line_clk <= 1'b1;
      repeat (4) @(posedge sys_clk);
      line_clk  <= 1'b0;
      line_data <= ~c[7:0];
      line_is_k <= ~c[8];
      line_inv_disp <= ~c[9];
   endtask
endmodule

// file: tb/test_ecc_top.sv
// Self-checking bench of the clock correction elastic buffer.
// Assumes the transmitter model drives the line side.
module test_ecc_top;
   timeunit 1ns;
   timeprecision 1ns;
   import ecc_pkg::*;
   logic sys_clk = 1'b0, rstn = 1'b0, cc_enable = 1'b0, cc_two_seq = 1'b0, rx_ready = 1'b0;
   logic line_clk, line_is_k, line_inv_disp, rx_is_k, rx_valid, cc_deleted, cc_inserted, buf_overflow;
   logic [7:0] line_data, rx_data;
   logic [5:0] buf_level;
   logic [7:0] cc_sym_k = 8'h11, cc_sym_dc = 8'hee, cc_sym_inv = 8'h00;
   logic [8:0] got[$], exp_q[$];
   int num_errors = 0, tests_run = 0, n_del = 0, n_ins = 0;
   always #50 sys_clk = ~sys_clk;
   ecc_tx_model i_tx (.sys_clk(sys_clk), .line_clk(line_clk), .line_data(line_data),
      .line_is_k(line_is_k), .line_inv_disp(line_inv_disp));
   ecc_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .line_clk(line_clk), .line_data(line_data),
      .line_is_k(line_is_k), .line_inv_disp(line_inv_disp), .cc_enable(cc_enable),
      .cc_two_seq(cc_two_seq), .cc_seq_len(3'h1), .cc_max_lat(6'h14), .cc_min_lat(6'h12),
      .cc_sym({24'h000000, 8'hbc, 24'h000000, 8'h1c}), .cc_sym_k(cc_sym_k), .cc_sym_dc(cc_sym_dc),
      .cc_sym_inv(cc_sym_inv), .rx_data(rx_data), .rx_is_k(rx_is_k), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .buf_level(buf_level), .cc_deleted(cc_deleted),
      .cc_inserted(cc_inserted), .buf_overflow(buf_overflow));
   // *****************
   // Monitor
   // *****************
   always @(posedge sys_clk) begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1) got.push_back({rx_is_k, rx_data});
      if (cc_deleted === 1'b1) n_del++;
      if (cc_inserted === 1'b1) n_ins++;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask
   task automatic end_of_test;
      if (num_errors == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Sends one char, returns delete pulses seen and level change
   task automatic put(input logic [9:0] c, output int dd, output int dl);
      int d0, l0;
      d0 = n_del;
      l0 = buf_level;
      i_tx.send(c);
      repeat (8) @(posedge sys_clk);
      dd = n_del - d0;
      dl = buf_level - l0;
   endtask
   // *****************
   // Scenarios
   // *****************
   task automatic t_fill;
      int dd, dl;
      for (int i = 0; i < 26; i++) begin
         put({1'b0, 8'(i)}, dd, dl);
         exp_q.push_back({1'b0, 8'(i)});
      end
      check(buf_level > 6'h14, 1);
      check({rx_valid, rx_is_k, rx_data}, 10'h200);
   endtask
   task automatic t_nomatch;
      int dd, dl;
      put(9'h01c, dd, dl);
      check(dd, 0);
      put(9'h11d, dd, dl);
      check(dd, 0);
      check(dl, 1);
      exp_q.push_back(9'h01c);
      exp_q.push_back(9'h11d);
   endtask
   task automatic t_two_seq;
      int dd, dl;
      put(9'h1bc, dd, dl);
      check(dd, 0);
      exp_q.push_back(9'h1bc);
      // Flush the unmatched symbol out of the window before switching modes
      put(9'h066, dd, dl);
      check(dd, 0);
      exp_q.push_back(9'h066);
      @(posedge sys_clk) cc_two_seq <= 1'b1;
      put(9'h1bc, dd, dl);
      check(dd, 1);
   endtask
   task automatic t_delete;
      int dd, dl;
      put(9'h11c, dd, dl);
      check(dd, 1);
      check(dl, 0);
   endtask
   // Config changes only while the window holds an already matched symbol or 055, which no setting matches while cc_sym_dc is 8'hee
   task automatic t_disp;
      int dd, dl;
      @(posedge sys_clk) cc_sym_dc <= 8'hef;
      put(10'h077, dd, dl);
      check(dd, 1);
      @(posedge sys_clk) cc_sym_dc <= 8'hee;
      put(10'h31c, dd, dl);
      check(dd, 0);
      put(10'h055, dd, dl);
      check(dd, 0);
      exp_q.push_back(9'h055);
      @(posedge sys_clk) cc_sym_inv <= 8'h01;
      put(10'h31c, dd, dl);
      check(dd, 1);
   endtask
   task automatic t_drain;
      int dd, dl, k;
      check(n_ins, 0);
      @(posedge sys_clk) rx_ready <= 1'b1;
      repeat (300) @(posedge sys_clk);
      put(9'h11c, dd, dl);
      check(dd, 0);
      put(9'h11c, dd, dl);
      check(dd, 0);
      repeat (300) @(posedge sys_clk);
      check(n_ins > 0, 1);
      @(posedge sys_clk) cc_enable <= 1'b0;
      // Insertion traffic toggles valid; let the held characters stream out first
      repeat (40) @(posedge sys_clk);
      repeat (2000) @(posedge sys_clk) if (rx_valid !== 1'b1) break;
      check(rx_valid, 0);
      check(buf_level, 0);
      k = 0;
      foreach (got[i]) if (got[i] !== 9'h11c) begin
         if (k < exp_q.size()) check(got[i], exp_q[k]);
         k++;
      end
      check(k, exp_q.size());
      check(buf_overflow, 0);
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      #1 check({rx_valid, buf_level, cc_deleted, cc_inserted, buf_overflow}, 0);
      @(posedge sys_clk) cc_enable <= 1'b1;
      t_fill();
      t_nomatch();
      t_two_seq();
      t_delete();
      t_disp();
      t_drain();
      end_of_test();
   end
endmodule
